// >>> logic/pdsc_pkg.sv
// pdsc_pkg: shared constants of the power-down and self-test pin control block
`default_nettype none

package pdsc_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [7:0]  ADR_CTRL        = 8'h00;
    localparam logic [7:0]  ADR_STATUS      = 8'h04;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int          CTRL_W          = 4;
    localparam int          CTRL_INT_CLKSEL = 0;
    localparam int          CTRL_PIN3_GPIO  = 1;
    localparam int          CTRL_PIN3_DIR   = 2;
    localparam int          CTRL_PIN3_VAL   = 3;
    localparam logic [3:0]  CTRL_RST        = 4'h0;

    // ------------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------------
    localparam int          STAT_W          = 6;
    localparam int          STAT_POWERED    = 0;
    localparam int          STAT_SELF_TEST  = 1;
    localparam int          STAT_CLK_FAST   = 2;
    localparam int          STAT_EXT_INT    = 3;
    localparam int          STAT_PIN3_IN    = 4;
    localparam int          STAT_PLL_RUN    = 5;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          SYNC_STAGES     = 2;
    localparam int          FAST_CLK_MHZ    = 33;

endpackage : pdsc_pkg

`default_nettype wire

// >>> logic/pdsc_enable_sync.sv
// pdsc_enable_sync: brings the chip enable pin into the clock domain
`default_nettype none

module pdsc_enable_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic chip_enable_pin_i,
    output logic      enabled_o
);

    // ------------------------------------------------------------------
    // two-stage synchroniser
    // ------------------------------------------------------------------
    logic [pdsc_pkg::SYNC_STAGES-1:0] sync_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_r <= '0;
        end else begin
            sync_r <= {sync_r[0], chip_enable_pin_i};
        end
    end

    // fall takes effect at once, release waits for the last stage
    assign enabled_o = sync_r[pdsc_pkg::SYNC_STAGES-1] & chip_enable_pin_i;

endmodule : pdsc_enable_sync

`default_nettype wire

// >>> logic/pdsc_pin_control.sv
// pdsc_pin_control: chip enable, power-down, self-test and shared pin control
`default_nettype none

// Overview of operation
// - Taking the chip enable pin high starts normal operation with all registers at defaults.
// - While the chip enable pin is low the block stays powered down with everything idle.
// - Powered down, pin 3 floats, the interrupt pin is pulled low when INT_PULL_LOW is set, and the clock PLL is stopped.
// - The self-test enable pin disables self-test at 0 and enables it at 1.
// - In clock select role the shared pin picks pixel clock at 0 and the 33 MHz clock at 1.
// - The shared pin acts as external interrupt input after reset until software re-assigns it.
// - While the chip enable pin is low the external interrupt pin may be driven low.
// - The SPI select and fast general pin 3 function is chosen by a register bit.
module pdsc_pin_control #(
    parameter bit INT_PULL_LOW = 1'b1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // control pins
    input  wire logic        chip_enable_pin_i,
    input  wire logic        self_test_enable_pin_i,
    // shared pin: external interrupt input or self-test clock select
    input  wire logic        int_pin_i,
    output logic             int_pin_o,
    output logic             int_pin_oe_n_o,
    // shared pin: spi select or fast general pin 3
    input  wire logic        pin3_i,
    output logic             pin3_o,
    output logic             pin3_oe_n_o,
    // towards the core
    output logic             powered_o,
    output logic             core_rst_o,
    output logic             pll_enable_o,
    output logic             self_test_en_o,
    output logic             self_test_clk_fast_o,
    output logic             external_interrupt_input_o,
    output logic             spi_select_o,
    output logic             fast_general_pin_3_o
);

    // ------------------------------------------------------------------
    // enable synchronisation and internal reset
    // ------------------------------------------------------------------
    logic powered;
    logic core_rst;

    pdsc_enable_sync u_enable_sync (
        .clk_i             (clk_i),
        .rst_i             (rst_i),
        .chip_enable_pin_i (chip_enable_pin_i),
        .enabled_o         (powered)
    );

    assign core_rst   = rst_i | ~powered;
    assign powered_o  = powered;
    assign core_rst_o = core_rst;

    // ------------------------------------------------------------------
    // wishbone decode
    // ------------------------------------------------------------------
    logic                         ctrl_r;
    logic [pdsc_pkg::CTRL_W-1:0]  ctrl_q_r;
    logic                         ack_r;
    logic                         err_r;
    logic [31:0]                  rdat_r;
    logic                         req;
    logic                         hit_ctrl;
    logic                         hit_status;
    logic                         hit_any;
    logic                         ctrl_wr;
    logic [pdsc_pkg::CTRL_W-1:0]  ctrl_nxt;
    logic [pdsc_pkg::STAT_W-1:0]  status;
    logic [31:0]                  rdat_nxt;

    assign req        = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
    assign hit_ctrl   = wb_adr_i == pdsc_pkg::ADR_CTRL;
    assign hit_status = wb_adr_i == pdsc_pkg::ADR_STATUS;
    assign hit_any    = hit_ctrl | hit_status;
    // writes while powered down are dropped: the register is held in reset
    assign ctrl_wr    = req & wb_we_i & hit_ctrl & wb_sel_i[0];
    assign ctrl_nxt   = ctrl_wr ? wb_dat_i[pdsc_pkg::CTRL_W-1:0] : ctrl_q_r;

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            ctrl_q_r <= pdsc_pkg::CTRL_RST;
        end else begin
            ctrl_q_r <= ctrl_nxt;
        end
    end

    assign ctrl_r = ctrl_q_r[pdsc_pkg::CTRL_INT_CLKSEL];

    // ------------------------------------------------------------------
    // pin sampling into core-facing flops
    // ------------------------------------------------------------------
    logic clksel_mode;
    logic pin3_gpio;
    logic pin3_drive;
    logic self_test_r;
    logic clk_fast_r;
    logic ext_int_r;
    logic spi_sel_r;
    logic gpio3_in_r;
    logic pll_run_r;

    assign clksel_mode = ctrl_r;
    assign pin3_gpio   = ctrl_q_r[pdsc_pkg::CTRL_PIN3_GPIO];
    assign pin3_drive  = powered & pin3_gpio & ctrl_q_r[pdsc_pkg::CTRL_PIN3_DIR];

    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            self_test_r <= 1'b0;
            clk_fast_r  <= 1'b0;
            ext_int_r   <= 1'b0;
            spi_sel_r   <= 1'b0;
            gpio3_in_r  <= 1'b0;
            pll_run_r   <= 1'b0;
        end else begin
            self_test_r <= self_test_enable_pin_i;
            clk_fast_r  <= clksel_mode & int_pin_i;
            ext_int_r   <= ~clksel_mode & int_pin_i;
            spi_sel_r   <= ~pin3_gpio & pin3_i;
            gpio3_in_r  <= pin3_gpio & pin3_i;
            pll_run_r   <= 1'b1;
        end
    end

    assign self_test_en_o             = self_test_r;
    assign self_test_clk_fast_o       = clk_fast_r;
    assign external_interrupt_input_o = ext_int_r;
    assign spi_select_o               = spi_sel_r;
    assign fast_general_pin_3_o       = gpio3_in_r;
    // pll stops the moment the enable pin falls, not a cycle later
    assign pll_enable_o               = pll_run_r & powered;

    // ------------------------------------------------------------------
    // pad drivers (oe_n low while driving)
    // ------------------------------------------------------------------
    // interrupt pin pulls low only while powered down; otherwise it is an input
    assign int_pin_o      = 1'b0;
    assign int_pin_oe_n_o = ~(INT_PULL_LOW & ~powered);
    assign pin3_o         = ctrl_q_r[pdsc_pkg::CTRL_PIN3_VAL];
    assign pin3_oe_n_o    = ~pin3_drive;

    // ------------------------------------------------------------------
    // status and bus answer
    // ------------------------------------------------------------------
    assign status = {pll_enable_o, gpio3_in_r, ext_int_r, clk_fast_r, self_test_r, powered};

    assign rdat_nxt = hit_ctrl   ? {{(32-pdsc_pkg::CTRL_W){1'b0}}, ctrl_q_r} :
                      hit_status ? {{(32-pdsc_pkg::STAT_W){1'b0}}, status}   :
                                   32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            err_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r  <= req & hit_any;
            err_r  <= req & ~hit_any;
            rdat_r <= (req & ~wb_we_i) ? rdat_nxt : 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign wb_dat_o = rdat_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_enable_rise;
        $rose(chip_enable_pin_i);
    endsequence

    sequence s_enable_held;
        chip_enable_pin_i [*3];
    endsequence

    chk_enable_release: assert property (
        s_enable_rise ##0 s_enable_held |-> powered
    ) else $error("enable release not seen after two edges");

    chk_release_not_early: assert property (
        s_enable_rise |-> !powered
    ) else $error("enable released before synchronisation");

    chk_defaults_on_wake: assert property (
        $rose(powered) |-> ctrl_q_r == pdsc_pkg::CTRL_RST && !self_test_r
    ) else $error("registers not at default on wake");

    chk_powerdown_idle: assert property (
        !chip_enable_pin_i |=> !powered && !self_test_en_o && !pll_run_r
    ) else $error("block active while enable pin low");

    chk_powerdown_float: assert property (
        !powered |-> pin3_oe_n_o && !pll_enable_o
    ) else $error("output driven or pll running while powered down");

    chk_int_pull_low: assert property (
        !powered |-> int_pin_oe_n_o == !INT_PULL_LOW && !int_pin_o
    ) else $error("interrupt pin not pulled low while powered down");

    chk_int_released: assert property (
        powered |-> int_pin_oe_n_o
    ) else $error("interrupt pin driven while powered up");

    chk_self_test_follow: assert property (
        $past(powered) && powered |-> self_test_en_o == $past(self_test_enable_pin_i)
    ) else $error("self-test enable does not follow its pin");

    chk_clock_select: assert property (
        $past(powered) && $past(clksel_mode) && powered
            |-> self_test_clk_fast_o == $past(int_pin_i) && !external_interrupt_input_o
    ) else $error("self-test clock select wrong");

    chk_int_role: assert property (
        $past(powered) && !$past(clksel_mode) && powered
            |-> external_interrupt_input_o == $past(int_pin_i) && !self_test_clk_fast_o
    ) else $error("interrupt input role wrong");

    chk_pin3_role: assert property (
        powered && !pin3_gpio |-> pin3_oe_n_o ##1 (!powered || !fast_general_pin_3_o)
    ) else $error("pin 3 acts as gpio while in spi select role");

    chk_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o
    ) else $error("ack held longer than one cycle");

endmodule : pdsc_pin_control

`default_nettype wire

// >>> verification/pdsc_host_model.sv
// pdsc_host_model: host processor side of the control and shared pins
`default_nettype none

module pdsc_host_model (
    input  wire logic en_i,
    input  wire logic bist_i,
    input  wire logic int_lvl_i,
    input  wire logic p3_lvl_i,
    input  wire logic int_pin_o_i,
    input  wire logic int_pin_oe_n_i,
    input  wire logic pin3_o_i,
    input  wire logic pin3_oe_n_i,
    output logic      chip_enable_pin_o,
    output logic      self_test_enable_pin_o,
    output logic      int_pin_o,
    output logic      pin3_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // pin levels
    // ------------------------------------------------------------------
    assign chip_enable_pin_o      = en_i;
    assign self_test_enable_pin_o = bist_i;
    // device pull-low wins over the host level while enabled low
    assign int_pin_o = int_pin_oe_n_i ? int_lvl_i : int_pin_o_i;
    // host releases the gpio pin whenever the device drives it
    assign pin3_o    = pin3_oe_n_i ? p3_lvl_i : pin3_o_i;
endmodule : pdsc_host_model

`default_nettype wire

// >>> verification/tb.sv
// tb: self-checking bench of the power-down and self-test pin control block
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, rst_i, cyc, stb, we, en, bist, il, pl;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic        ack, err, e, ipo, ipoe, p3o, p3oe, pw, crst, pll, ste, fst, ext, spi, gp3;
    wire logic   en_w, bist_w, ip_w, p3_w;
    int          fails, compares, n;
    // ctrl, self-test pin, int pin, pin3 -> ste, fast, ext, spi, gpio3, pin3 oe_n
    localparam logic [12:0] ROWS [6] = '{13'b0000_000_000001, 13'b0000_111_101101,
        13'b0001_010_010001, 13'b0001_101_100101, 13'b0010_001_000011, 13'b1110_000_000010};

    pdsc_pin_control pdsc_pin_control_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .chip_enable_pin_i(en_w),
        .self_test_enable_pin_i(bist_w), .int_pin_i(ip_w), .int_pin_o(ipo),
        .int_pin_oe_n_o(ipoe), .pin3_i(p3_w), .pin3_o(p3o), .pin3_oe_n_o(p3oe),
        .powered_o(pw), .core_rst_o(crst), .pll_enable_o(pll), .self_test_en_o(ste),
        .self_test_clk_fast_o(fst), .external_interrupt_input_o(ext),
        .spi_select_o(spi), .fast_general_pin_3_o(gp3));
    pdsc_host_model pdsc_host_model_inst (.en_i(en), .bist_i(bist), .int_lvl_i(il),
        .p3_lvl_i(pl), .int_pin_o_i(ipo), .int_pin_oe_n_i(ipoe), .pin3_o_i(p3o),
        .pin3_oe_n_i(p3oe), .chip_enable_pin_o(en_w), .self_test_enable_pin_o(bist_w),
        .int_pin_o(ip_w), .pin3_o(p3_w));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] x, input string m);
        compares++;
        if (s !== x) begin
            fails++;
            $display("unexpected at %0t: %s seen %h wanted %h", $time, m, s, x);
        end
    endtask : chk

    // one classic cycle; holds the request until ack or err is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= s;
        // no cycle count assumed: only the watchdog ends a hung access
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1 && err !== 1'b1);
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic power_up();
        @(posedge clk_i);
        en <= 1'b1;
        @(posedge clk_i);
        #1 chk(pw, 1'b0, "powered early");
        n = 0;
        while (pw !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            #1 n++;
        end
        chk({pw, crst, ipoe}, 3'b101, "power up");
    endtask : power_up

    task automatic finish_test();
        $display("counts: compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #20000;
        fails++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        {cyc, stb, we, en, il, pl} = '0;
        bist     = 1'b1;
        adr      = '0;
        sel      = '0;
        wdat     = '0;
        fails    = 0;
        compares = 0;
        rst_i    = 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        // ------------------------------------------------------------------
        // powered down after reset
        // ------------------------------------------------------------------
        #1 chk({pw, crst, pll, ipoe, ipo, p3oe, ste}, 7'b0100010, "down");
        wb(1'b0, pdsc_pkg::ADR_CTRL, 32'h0, 4'hF);
        chk(q, 32'h0, "ctrl down");
        bist <= 1'b0;
        power_up();
        repeat (3) @(posedge clk_i);
        wb(1'b0, pdsc_pkg::ADR_STATUS, 32'h0, 4'hF);
        chk(q, 32'h21, "status");
        wb(1'b0, pdsc_pkg::ADR_CTRL, 32'h0, 4'hF);
        chk(q, {28'h0, pdsc_pkg::CTRL_RST}, "ctrl reset");
        $display("test reset done");
        // ------------------------------------------------------------------
        // table of pin roles
        // ------------------------------------------------------------------
        for (int r = 0; r < 6; r++) begin
            wb(1'b1, pdsc_pkg::ADR_CTRL, {28'h0, ROWS[r][12:9]}, 4'hF);
            bist <= ROWS[r][8];
            il   <= ROWS[r][7];
            pl   <= ROWS[r][6];
            repeat (3) @(posedge clk_i);
            #1 chk({ste, fst, ext, spi, gp3, p3oe}, ROWS[r][5:0], "pins");
            chk(p3o, ROWS[r][12], "pin3 value");
        end
        $display("test table done");
        // ------------------------------------------------------------------
        // refused accesses
        // ------------------------------------------------------------------
        wb(1'b1, pdsc_pkg::ADR_CTRL, 32'h1, 4'hE);
        wb(1'b0, pdsc_pkg::ADR_CTRL, 32'h0, 4'hF);
        chk(q, 32'hE, "sel ignored");
        wb(1'b0, 8'h08, 32'h0, 4'hF);
        chk({e, q}, {1'b1, 32'h0}, "unmapped");
        $display("test refusals done");
        // ------------------------------------------------------------------
        // power down in mid-run, then up again
        // ------------------------------------------------------------------
        @(posedge clk_i);
        en <= 1'b0;
        bist <= 1'b1;
        #1 chk(pw, 1'b0, "drop");
        @(posedge clk_i);
        #1 chk({ste, pll, p3oe, ipoe, crst}, 5'b00101, "down again");
        power_up();
        wb(1'b0, pdsc_pkg::ADR_CTRL, 32'h0, 4'hF);
        chk(q, 32'h0, "ctrl default");
        $display("test power cycle done");
        finish_test();
    end
endmodule : tb

`default_nettype wire
